// ### design/rlsync_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef RLSYNC_REGS_SVH
`define RLSYNC_REGS_SVH

// Register offsets
`define RL_ADDR_SERIAL_CFG 13'h0000
`define RL_ADDR_RB_RST_CTRL 13'h0004
`define RL_ADDR_UPDATE 13'h0005
`define RL_ADDR_LOSS_STS 13'h0081
`define RL_ADDR_ACT_REF 13'h0082
`define RL_ADDR_LOCK_PIN 13'h0083
`define RL_ADDR_LOSS_PIN 13'h0084
`define RL_ADDR_ALT_PIN 13'h0085

// Field positions
`define RL_LSB_FIRST_BIT 6
`define RL_SOFT_RST_BIT 5
`define RL_HARD_RST_BIT 4
`define RL_DRIVE_BIT 1
`define RL_READBACK_BIT 0
`define RL_UPDATE_BIT 0
`define RL_ACT_REF_BIT 0
`define RL_MASK_MSB 4
`define RL_INV_BIT 5
`define RL_3V3_BIT 6

// Reset values
`define RL_CTRL_RST 8'h00

// Loss timer: 500 ns at a 25 ns clock
`define RL_CLK_PERIOD_NS 25
`define RL_TIMEOUT_NS 500
`define RL_TIMEOUT_CYC (`RL_TIMEOUT_NS / `RL_CLK_PERIOD_NS)

// Lock detector hysteresis (frequency detector, phase detectors)
`define RL_FLD_SET 8'h20
`define RL_FLD_CLR 8'h08
`define RL_FLD_ERR 8'h04
`define RL_PLD_SET 8'h40
`define RL_PLD_CLR 8'h10
`define RL_PLD_ERR 8'h08

`endif

// ### design/rlsync_pkg.sv
// Types shared by the reference loss and lock status block
package rlsync_pkg;

   // Per-PLL reset sequence state
   typedef enum logic [4:0] {
      SEQ_IDLE = 5'b00001,
      SEQ_WAIT_REF = 5'b00010,
      SEQ_CAL = 5'b00100,
      SEQ_LOCK = 5'b01000,
      SEQ_SYNC = 5'b10000
   } rlsync_seq_t;

   // Five loss indications: third_pll_ref, second_pll_ref, active, first_ref_b, first_ref_a
   typedef logic [4:0] rlsync_ind_t;

endpackage

// ### design/rlsync_det_if.sv
// Link between the status logic and one reference loss detector
interface rlsync_det_if;
   logic ref_lvl;
   logic restart;
   logic loss;

   modport det (input ref_lvl, input restart, output loss);
   modport ctl (output ref_lvl, output restart, input loss);
endinterface

// ### design/rlsync_loss_det.sv
// One reference loss detector with high and low half cycle timers
`include "rlsync_regs.svh"

module rlsync_loss_det
   import rlsync_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Detector link
   rlsync_det_if.det det
);

   logic ref_q;
   logic seen_q;
   logic hi_run_q;
   logic lo_run_q;
   logic hi_exp_q;
   logic lo_exp_q;
   logic loss_q;
   logic [5:0] hi_cnt_q;
   logic [5:0] lo_cnt_q;
   logic [5:0] hrun_q;
   logic up;
   logic dn;

   // Edge pulses from the sampled reference
   assign up = det.ref_lvl & ~ref_q;
   assign dn = ~det.ref_lvl & ref_q;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ref_q <= 1'b0;
      end else begin
         ref_q <= det.ref_lvl;
      end
   end

   // High half timer: started by up, cleared by down
   always_ff @(posedge sys_clk) begin
      if (sys_rst || det.restart || dn) begin
         hi_run_q <= 1'b0;
         hi_exp_q <= 1'b0;
         hi_cnt_q <= 6'h00;
      end else if (up) begin
         hi_run_q <= 1'b1;
         hi_exp_q <= 1'b0;
         hi_cnt_q <= 6'h00;
      end else if (hi_run_q) begin
         if (hi_cnt_q == 6'(`RL_TIMEOUT_CYC)) begin
            hi_exp_q <= 1'b1;
            hi_run_q <= 1'b0;
         end else begin
            hi_cnt_q <= hi_cnt_q + 6'h01;
         end
      end
   end

   // Low half timer: started by down, cleared by up
   always_ff @(posedge sys_clk) begin
      if (sys_rst || det.restart || up) begin
         lo_run_q <= 1'b0;
         lo_exp_q <= 1'b0;
         lo_cnt_q <= 6'h00;
      end else if (dn) begin
         lo_run_q <= 1'b1;
         lo_exp_q <= 1'b0;
         lo_cnt_q <= 6'h00;
      end else if (lo_run_q) begin
         if (lo_cnt_q == 6'(`RL_TIMEOUT_CYC)) begin
            lo_exp_q <= 1'b1;
            lo_run_q <= 1'b0;
         end else begin
            lo_cnt_q <= lo_cnt_q + 6'h01;
         end
      end
   end

   // Activity seen since the last reset event
   always_ff @(posedge sys_clk) begin
      if (sys_rst || det.restart) begin
         seen_q <= 1'b0;
      end else if (up || dn) begin
         seen_q <= 1'b1;
      end
   end

   // No memory: loss only reflects the present timer state and the activity seen flag
   always_ff @(posedge sys_clk) begin
      if (sys_rst || det.restart) begin
         loss_q <= 1'b1;
      end else begin
         loss_q <= ~seen_q | hi_exp_q | lo_exp_q;
      end
   end

   assign det.loss = loss_q;

   // Helper: length of the current level run, high or low, for checking only
   always_ff @(posedge sys_clk) begin
      if (sys_rst || up || dn) begin
         hrun_q <= 6'h00;
      end else if (hrun_q != 6'h3f) begin
         hrun_q <= hrun_q + 6'h01;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   sequence s_toggle;
      (det.ref_lvl && !det.restart) [*4] ##1 (!det.ref_lvl && !det.restart) [*4] ##1
      (det.ref_lvl && !det.restart) [*4] ##1 (!det.ref_lvl && !det.restart);
   endsequence

   chk_restart_loss: assert property (det.restart |=> det.loss [*2])
      else $error("loss not raised after reset event");
   chk_stuck_high: assert property ((hrun_q == 6'h18) |-> det.loss)
      else $error("stuck reference not reported");
   chk_loss_clears: assert property (s_toggle ##1 !det.restart [*2] |-> !det.loss)
      else $error("loss held after activity returned");

endmodule // rlsync_loss_det

// ### design/rlsync_top.sv
// Reference loss, lock indication and reset sequence status block
//
// Behaviour
// - One independent loss detector for each of the four reference inputs.
// - Each detector holds two half cycle timers of 500 ns.
// - Loss indication is not latched; it follows the present detector state.
// - After any reset event loss is asserted until reference activity is seen.
// - Rising edge starts high timer, falling edge starts low timer, each clearing other.
// - A half cycle longer than the timer period asserts loss for that input.
// - Both first PLL references report loss regardless of which one is active.
// - Read-only bit shows active first PLL reference: 0 is A, 1 is B.
// - Five indications: ref A, ref B, active, second ref, third ref.
// - Third PLL loss comes only from the first stage of its cascade.
// - Each loss pin shows the OR of indications enabled in its mask.
// - Dedicated loss pin is undriven when its whole mask is zero.
// - Borrowed pin carries third PLL clock with zero mask, else masked loss.
// - Dedicated pin polarity bit zero means loss drives one.
// - Borrowed pin uses same polarity scheme with its own invert bit.
// - Per-PLL lock detector from detector activity, with hysteresis against chatter.
// - Each lock pin has an invert bit; zero means lock drives one.
// - Power-on, profile load, soft or hard reset runs sequence ending in sync.
// - Sync makes all output channels of a PLL start together.
// - Calibrate and sync after the sequence run standalone, no sequence re-entry.
// - First PLL sequence judges reference by the dedicated pin selection bits.
// - Third PLL sequence skips calibration; second skips oscillator and delay waits.
// - Sync requested before lock waits for lock; otherwise on request falling edge.
`include "rlsync_regs.svh"

module rlsync_top
   import rlsync_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [12:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Reference inputs and active reference select
   input wire logic first_ref_a,
   input wire logic first_ref_b,
   input wire logic second_pll_ref,
   input wire logic third_pll_ref,
   input wire logic ref1_sel,
   // Reset events from outside the block
   input wire logic profile_load,
   // PLL activity and sequencing handshakes
   input wire logic [2:0] pfd_cmp,
   input wire logic [2:0] pfd_err,
   input wire logic [2:0] cal_done,
   input wire logic pll1_ext_osc_en,
   input wire logic pll1_fixed_delay_en,
   input wire logic fixed_delay_done,
   input wire logic pll3_clk,
   // Standalone commands
   input wire logic [2:0] cal_cmd,
   input wire logic [2:0] sync_cmd,
   // Status pins
   output logic [2:0] lock_indicator_pins,
   output logic loss_status_pin,
   output logic loss_status_pin_oe,
   output logic third_pll_single_output,
   // Sequencing outputs
   output logic [2:0] cal_start,
   output logic [2:0] chan_sync,
   output logic [2:0] seq_busy
);

   // Control registers
   logic [7:0] serial_config_q;
   logic [7:0] readback_and_reset_ctrl_q;
   logic [7:0] lock_pin_ctrl_q;
   logic [7:0] loss_pin_ctrl_q;
   logic [7:0] alt_loss_pin_ctrl_q;
   logic [7:0] reg_rdata_q;
   logic restart_q;

   // Detector path
   logic [3:0] ref_vec;
   logic [3:0] det_loss;
   logic [3:0] loss_s1_q;
   logic [3:0] loss_s2_q;
   logic act_ref_q;
   rlsync_ind_t ref_loss;
   logic [2:0] seq_loss;

   // Lock detection
   logic [7:0] lock_cnt_q [3];
   logic [2:0] lock_q;

   // Sequencer
   rlsync_seq_t seq_q [3];
   logic [2:0] sync_prev_q;
   logic [2:0] sync_pend_q;
   logic [2:0] cal_start_q;
   logic [2:0] chan_sync_q;
   logic [2:0] busy_q;

   // Pins
   logic [2:0] lock_pins_q;
   logic loss_pin_q;
   logic loss_pin_oe_q;
   logic alt_pin_q;

   logic wr_soft;
   logic wr_hard;

   // Saturating up/down step for the lock hysteresis counters
   function automatic logic [7:0] sat_step(input logic [7:0] cnt, input logic err, input logic [7:0] dec);
      logic [7:0] r;
      r = cnt;
      if (err) begin
         r = (cnt < dec) ? 8'h00 : cnt - dec;
      end else if (cnt != 8'hff) begin
         r = cnt + 8'h01;
      end
      return r;
   endfunction

   // Frequency detector thresholds for the first PLL, phase detector for the rest
   function automatic logic [7:0] lock_thr(input int idx, input int sel);
      logic [7:0] r;
      r = 8'h00;
      case (sel)
         0: r = (idx == 0) ? `RL_FLD_SET : `RL_PLD_SET;
         1: r = (idx == 0) ? `RL_FLD_CLR : `RL_PLD_CLR;
         default: r = (idx == 0) ? `RL_FLD_ERR : `RL_PLD_ERR;
      endcase
      return r;
   endfunction

   // Calibration step: skipped on third PLL and with the external oscillator
   function automatic logic needs_cal(input int idx, input logic ext_osc);
      return (idx == 0) ? ~ext_osc : (idx == 1);
   endfunction

   // Register write decode for the self-clearing reset bits
   assign wr_soft = reg_wr && (reg_addr == `RL_ADDR_SERIAL_CFG) && reg_wdata[`RL_SOFT_RST_BIT];
   assign wr_hard = reg_wr && (reg_addr == `RL_ADDR_RB_RST_CTRL) && reg_wdata[`RL_HARD_RST_BIT];

   // Reset event pulse; held high through the system reset and one cycle past its release as power-on
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         restart_q <= 1'b1;
      end else begin
         restart_q <= profile_load | wr_soft | wr_hard;
      end
   end

   // Writable registers; reset bits and the update bit do not store
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         serial_config_q <= `RL_CTRL_RST;
         readback_and_reset_ctrl_q <= `RL_CTRL_RST;
         lock_pin_ctrl_q <= `RL_CTRL_RST;
         loss_pin_ctrl_q <= `RL_CTRL_RST;
         alt_loss_pin_ctrl_q <= `RL_CTRL_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            `RL_ADDR_SERIAL_CFG: serial_config_q <= reg_wdata & 8'hdf;
            `RL_ADDR_RB_RST_CTRL: readback_and_reset_ctrl_q <= reg_wdata & 8'hef;
            `RL_ADDR_LOCK_PIN: lock_pin_ctrl_q <= reg_wdata;
            `RL_ADDR_LOSS_PIN: loss_pin_ctrl_q <= reg_wdata;
            `RL_ADDR_ALT_PIN: alt_loss_pin_ctrl_q <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Read data, one cycle after the read strobe; unmapped reads zero
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `RL_ADDR_SERIAL_CFG: reg_rdata_q <= serial_config_q;
            `RL_ADDR_RB_RST_CTRL: reg_rdata_q <= readback_and_reset_ctrl_q;
            `RL_ADDR_LOSS_STS: reg_rdata_q <= {3'h0, ref_loss};
            `RL_ADDR_ACT_REF: reg_rdata_q <= {7'h00, act_ref_q};
            `RL_ADDR_LOCK_PIN: reg_rdata_q <= lock_pin_ctrl_q;
            `RL_ADDR_LOSS_PIN: reg_rdata_q <= loss_pin_ctrl_q;
            `RL_ADDR_ALT_PIN: reg_rdata_q <= alt_loss_pin_ctrl_q;
            default: reg_rdata_q <= 8'h00;
         endcase
      end
   end

   // One detector per reference; the third PLL's is its first cascade stage
   assign ref_vec = {third_pll_ref, second_pll_ref, first_ref_b, first_ref_a};

   for (genvar g = 0; g < 4; g++) begin : g_det
      rlsync_det_if det_if ();
      assign det_if.ref_lvl = ref_vec[g];
      assign det_if.restart = restart_q;
      assign det_loss[g] = det_if.loss;
      rlsync_loss_det u_det (
         .sys_clk(sys_clk),
         .sys_rst(sys_rst),
         .det(det_if.det)
      );
   end

   // Two-stage synchroniser between detector and status; first stage feeds only the second
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         loss_s1_q <= 4'hf;
         loss_s2_q <= 4'hf;
      end else begin
         loss_s1_q <= det_loss;
         loss_s2_q <= loss_s1_q;
      end
   end

   // Active reference status bit
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         act_ref_q <= 1'b0;
      end else begin
         act_ref_q <= ref1_sel;
      end
   end

   // Five indications; A and B reported whatever the active choice is
   assign ref_loss = {loss_s2_q[3], loss_s2_q[2], (act_ref_q ? loss_s2_q[1] : loss_s2_q[0]),
                      loss_s2_q[1], loss_s2_q[0]};

   // Reference judged by the sequencers; an empty selection falls back to active
   assign seq_loss[0] = (loss_pin_ctrl_q[2:0] == 3'h0) ? ref_loss[2] :
                        |(loss_pin_ctrl_q[2:0] & ref_loss[2:0]);
   assign seq_loss[1] = ref_loss[3];
   assign seq_loss[2] = ref_loss[4];

   // Lock detectors: counter rises on clean compares, drops on errors, two thresholds
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < 3; i++) begin
         if (sys_rst || restart_q) begin
            lock_cnt_q[i] <= 8'h00;
            lock_q[i] <= 1'b0;
         end else begin
            if (pfd_cmp[i]) begin
               lock_cnt_q[i] <= sat_step(lock_cnt_q[i], pfd_err[i], lock_thr(i, 2));
            end
            if (lock_cnt_q[i] >= lock_thr(i, 0)) begin
               lock_q[i] <= 1'b1;
            end else if (lock_cnt_q[i] <= lock_thr(i, 1)) begin
               lock_q[i] <= 1'b0;
            end
         end
      end
   end

   // Reset sequencers and standalone commands, one per PLL
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < 3; i++) begin
         if (sys_rst) begin
            seq_q[i] <= SEQ_IDLE;
            sync_pend_q[i] <= 1'b0;
            cal_start_q[i] <= 1'b0;
            chan_sync_q[i] <= 1'b0;
         end else if (restart_q) begin
            seq_q[i] <= SEQ_WAIT_REF;
            sync_pend_q[i] <= 1'b0;
            cal_start_q[i] <= 1'b0;
            chan_sync_q[i] <= 1'b0;
         end else begin
            cal_start_q[i] <= 1'b0;
            chan_sync_q[i] <= 1'b0;
            unique case (seq_q[i])
               SEQ_WAIT_REF: begin
                  if (!seq_loss[i]) begin
                     if (needs_cal(i, pll1_ext_osc_en)) begin
                        seq_q[i] <= SEQ_CAL;
                        cal_start_q[i] <= 1'b1;
                     end else begin
                        seq_q[i] <= SEQ_LOCK;
                     end
                  end
               end
               SEQ_CAL: begin
                  if (seq_loss[i]) begin
                     seq_q[i] <= SEQ_WAIT_REF;
                  end else if (cal_done[i]) begin
                     seq_q[i] <= SEQ_LOCK;
                  end
               end
               SEQ_LOCK: begin
                  if (seq_loss[i]) begin
                     seq_q[i] <= SEQ_WAIT_REF;
                  end else if (lock_q[i] && (i != 0 || !pll1_fixed_delay_en || fixed_delay_done)) begin
                     seq_q[i] <= SEQ_SYNC;
                  end
               end
               SEQ_SYNC: begin
                  chan_sync_q[i] <= 1'b1;
                  seq_q[i] <= SEQ_IDLE;
               end
               SEQ_IDLE: begin
                  if (cal_cmd[i]) begin
                     cal_start_q[i] <= 1'b1;
                  end
                  if (sync_prev_q[i] && !sync_cmd[i]) begin
                     if (lock_q[i]) begin
                        chan_sync_q[i] <= 1'b1;
                        sync_pend_q[i] <= 1'b0;
                     end else begin
                        sync_pend_q[i] <= 1'b1;
                     end
                  end else if (sync_pend_q[i] && lock_q[i]) begin
                     chan_sync_q[i] <= 1'b1;
                     sync_pend_q[i] <= 1'b0;
                  end
               end
            endcase
         end
      end
   end

   // Sync request history for the falling edge, and busy flags
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < 3; i++) begin
         if (sys_rst) begin
            sync_prev_q[i] <= 1'b0;
            busy_q[i] <= 1'b0;
         end else begin
            sync_prev_q[i] <= sync_cmd[i];
            busy_q[i] <= (seq_q[i] != SEQ_IDLE);
         end
      end
   end

   // Lock pins with per-pin invert at bits 0, 2 and 4
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         lock_pins_q <= 3'h0;
      end else begin
         lock_pins_q <= lock_q ^ {lock_pin_ctrl_q[4], lock_pin_ctrl_q[2], lock_pin_ctrl_q[0]};
      end
   end

   // Dedicated loss pin; undriven while nothing is selected
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         loss_pin_q <= 1'b0;
         loss_pin_oe_q <= 1'b0;
      end else begin
         loss_pin_q <= loss_pin_ctrl_q[`RL_INV_BIT] ^ |(loss_pin_ctrl_q[`RL_MASK_MSB:0] & ref_loss);
         loss_pin_oe_q <= |loss_pin_ctrl_q[`RL_MASK_MSB:0];
      end
   end

   // Borrowed pin: the PLL clock is resampled here, so its edges land on the system clock grid
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         alt_pin_q <= 1'b0;
      end else if (alt_loss_pin_ctrl_q[`RL_MASK_MSB:0] == 5'h00) begin
         alt_pin_q <= pll3_clk;
      end else begin
         alt_pin_q <= alt_loss_pin_ctrl_q[`RL_INV_BIT] ^ |(alt_loss_pin_ctrl_q[`RL_MASK_MSB:0] & ref_loss);
      end
   end

   assign reg_rdata = reg_rdata_q;
   assign lock_indicator_pins = lock_pins_q;
   assign loss_status_pin = loss_pin_q;
   assign loss_status_pin_oe = loss_pin_oe_q;
   assign third_pll_single_output = alt_pin_q;
   assign cal_start = cal_start_q;
   assign chan_sync = chan_sync_q;
   assign seq_busy = busy_q;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   sequence s_seq_end(int i);
      seq_q[i] == SEQ_SYNC ##1 (chan_sync[i] && seq_q[i] == SEQ_IDLE);
   endsequence

   chk_pin_hiz: assert property ((loss_pin_ctrl_q[4:0] == 5'h00) |=> !loss_status_pin_oe)
      else $error("loss pin driven with empty mask");
   chk_pin_level: assert property ((loss_pin_ctrl_q[4:0] != 5'h00) |=>
      loss_status_pin == ($past(loss_pin_ctrl_q[5]) ^ |($past(loss_pin_ctrl_q[4:0]) & $past(ref_loss))))
      else $error("loss pin level wrong");
   chk_alt_clock: assert property ((alt_loss_pin_ctrl_q[4:0] == 5'h00) |=> third_pll_single_output == $past(pll3_clk))
      else $error("borrowed pin not carrying clock");
   chk_alt_level: assert property ((alt_loss_pin_ctrl_q[4:0] != 5'h00) |=> third_pll_single_output ==
      ($past(alt_loss_pin_ctrl_q[5]) ^ |($past(alt_loss_pin_ctrl_q[4:0]) & $past(ref_loss))))
      else $error("borrowed pin loss level wrong");
   chk_lock_pol: assert property (##1 lock_indicator_pins[1] == ($past(lock_q[1]) ^ $past(lock_pin_ctrl_q[2])))
      else $error("lock pin polarity wrong");
   chk_status_sync: assert property (##2 loss_s2_q == $past(det_loss, 2))
      else $error("loss synchroniser depth wrong");
   chk_seq_restart: assert property (restart_q |=> seq_q[0] == SEQ_WAIT_REF && seq_q[2] == SEQ_WAIT_REF)
      else $error("reset event did not start sequence");
   chk_seq_end: assert property (seq_q[1] == SEQ_SYNC && !restart_q |-> s_seq_end(1))
      else $error("sequence did not end in sync");
   chk_cal_alone: assert property (seq_q[0] == SEQ_IDLE && cal_cmd[0] && !restart_q |=>
      cal_start[0] && seq_q[0] == SEQ_IDLE)
      else $error("standalone calibrate wrong");
   chk_sync_wait: assert property (seq_q[2] == SEQ_IDLE && sync_prev_q[2] && !sync_cmd[2] && !lock_q[2] &&
      !restart_q |=> !chan_sync[2] && sync_pend_q[2])
      else $error("sync before lock not postponed");
   chk_no_cal3: assert property (seq_q[2] != SEQ_CAL)
      else $error("third PLL entered calibration");

endmodule // rlsync_top

// ### tb/rlsync_ref_src.sv
// Reference clock sources with per-input run control
module rlsync_ref_src (
   // Clock
   input wire logic sys_clk,
   // Run control, one bit per reference
   input wire logic [3:0] run,
   // Reference levels
   output logic [3:0] refs
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] cnt_q = 2'h0;
   initial refs = 4'h0;
   // Half period of four cycles, well inside the timeout; a stopped source holds its level
   always @(negedge sys_clk) begin
      cnt_q <= cnt_q + 2'h1;
      if (cnt_q == 2'h3) refs <= refs ^ run;
   end
endmodule // rlsync_ref_src

// ### tb/tb_rlsync_top.sv
// Self-checking bench for the loss, lock and sync status block
module tb_rlsync_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, ref1_sel = 0, profile_load = 0, pll3_clk = 0;
   logic [12:0] reg_addr = 13'h0;
   logic [7:0] reg_wdata = 8'h0, reg_rdata;
   logic [3:0] run = 4'h0, refs;
   logic [2:0] pfd_cmp = 3'h0, cal_cmd = 3'h0, sync_cmd = 3'h0, lock_pins, cal_start, chan_sync, seq_busy;
   logic [2:0] sync_seen = 3'h0, cal_seen = 3'h0, pfd_err = 3'h0;
   logic ext_osc = 0, fd_en = 0, fd_done = 0;
   logic loss_pin, loss_oe, alt_pin;
   int err_count = 0, n_checks = 0, cyc = 0;

   rlsync_ref_src src_u (.sys_clk(sys_clk), .run(run), .refs(refs));
   rlsync_top dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .first_ref_a(refs[0]),
      .first_ref_b(refs[1]), .second_pll_ref(refs[2]), .third_pll_ref(refs[3]), .ref1_sel(ref1_sel),
      .profile_load(profile_load), .pfd_cmp(pfd_cmp), .pfd_err(pfd_err), .cal_done(3'h7),
      .pll1_ext_osc_en(ext_osc), .pll1_fixed_delay_en(fd_en), .fixed_delay_done(fd_done), .pll3_clk(pll3_clk),
      .cal_cmd(cal_cmd), .sync_cmd(sync_cmd), .lock_indicator_pins(lock_pins), .loss_status_pin(loss_pin),
      .loss_status_pin_oe(loss_oe), .third_pll_single_output(alt_pin), .cal_start(cal_start),
      .chan_sync(chan_sync), .seq_busy(seq_busy));

   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end

   // Pulses stand one cycle, so capture them sticky; cycle ceiling cuts a hang
   always @(posedge sys_clk) begin
      sync_seen <= sync_seen | chan_sync;
      cal_seen <= cal_seen | cal_start;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         test_done();
      end
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One register access: strobe for a single cycle, data read after it
   task automatic acc(input logic [12:0] a, input logic [7:0] d, input logic wr);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = wr;
      reg_rd = !wr;
      @(negedge sys_clk);
      reg_wr = 0;
      reg_rd = 0;
   endtask

   task automatic wt(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic test_done();
      $display("checks=%0d errors=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   initial begin
      wt(20);
      chk({loss_oe, lock_pins, seq_busy}, 8'h00);
      sys_rst = 0;
      acc(13'h81, 8'h00, 0);
      chk(reg_rdata, 8'h1f);
      // Pin control registers reset clear; unmapped place reads zero
      acc(13'h90, 8'hff, 1);
      for (int i = 0; i < 4; i++) begin
         acc(13'h83 + i[12:0], 8'h00, 0);
         chk(reg_rdata, 8'h00);
      end
      run = 4'hf;
      pfd_cmp = 3'h7;
      wt(60);
      acc(13'h81, 8'h00, 0);
      chk(reg_rdata, 8'h00);
      acc(13'h82, 8'h00, 0);
      chk(reg_rdata, 8'h00);
      ref1_sel = 1;
      acc(13'h82, 8'h00, 1);
      acc(13'h82, 8'h00, 0);
      chk(reg_rdata, 8'h01);
      // Stop reference B only: both first references still reported
      run = 4'hd;
      wt(40);
      acc(13'h81, 8'h00, 0);
      chk(reg_rdata, 8'h06);
      ref1_sel = 0;
      wt(4);
      acc(13'h81, 8'h00, 0);
      chk(reg_rdata, 8'h02);
      acc(13'h84, 8'h02, 1);
      wt(3);
      chk({loss_oe, loss_pin}, 8'h03);
      acc(13'h84, 8'h22, 1);
      wt(3);
      chk({loss_oe, loss_pin}, 8'h02);
      acc(13'h84, 8'h00, 1);
      wt(3);
      chk(loss_oe, 8'h00);
      pll3_clk = 1;
      wt(3);
      chk(alt_pin, 8'h01);
      pll3_clk = 0;
      wt(3);
      chk(alt_pin, 8'h00);
      acc(13'h85, 8'h02, 1);
      wt(3);
      chk(alt_pin, 8'h01);
      acc(13'h85, 8'h22, 1);
      wt(3);
      chk(alt_pin, 8'h00);
      run = 4'hf;
      wt(40);
      acc(13'h81, 8'h00, 0);
      chk(reg_rdata, 8'h00);
      chk({lock_pins, sync_seen}, 8'h3f);
      acc(13'h83, 8'h15, 1);
      wt(3);
      chk(lock_pins, 8'h00);
      sync_seen = 0;
      cal_seen = 0;
      sync_cmd = 3'h7;
      wt(1);
      sync_cmd = 3'h0;
      wt(3);
      chk(sync_seen, 8'h07);
      cal_cmd = 3'h7;
      wt(1);
      cal_cmd = 3'h0;
      wt(3);
      chk(cal_seen, 8'h07);
      // Soft reset, hard reset, profile load each rerun the sequence
      // Hard reset run: PLL1 skips calibration and holds its sync for the fixed delay
      for (int e = 0; e < 3; e++) begin
         ext_osc = (e == 1);
         fd_en = (e == 1);
         fd_done = 0;
         if (e == 0) acc(13'h00, 8'h20, 1);
         else if (e == 1) acc(13'h04, 8'h10, 1);
         else acc(13'h05, 8'h00, 0);
         profile_load = (e == 2);
         wt(1);
         profile_load = 0;
         wt(3);
         chk(seq_busy, 8'h07);
         sync_seen = 0;
         cal_seen = 0;
         wt(300);
         chk({cal_seen, sync_seen}, (e == 1) ? 8'h16 : 8'h1f);
         fd_done = 1;
         wt(3);
         chk(sync_seen, 8'h07);
      end
      // Errors drain the lock counters; relock needs the full set count again
      pfd_err = 3'h7;
      wt(80);
      chk(lock_pins, 8'h07);
      sync_seen = 0;
      sync_cmd = 3'h7;
      wt(1);
      sync_cmd = 3'h0;
      wt(3);
      chk(sync_seen, 8'h00);
      pfd_err = 3'h0;
      wt(20);
      chk(lock_pins, 8'h07);
      wt(60);
      chk({lock_pins, sync_seen}, 8'h07);
      test_done();
   end
endmodule // tb_rlsync_top
